// *** rtl/conv_trigger_result.sv ***
// conversion sequencing, trigger selection, result registers and interrupts
`timescale 1ns/1ps
// What this block does
// - completion interrupt request only when its enable and global enable are set.
// - converter clock is system clock divided by 2,2,4,8,16,32,64,128.
// - right adjusted: high bits 1:0 hold result 9:8, low holds 7:0.
// - left adjusted: high holds result 9:2, low bits 7:6 hold 1:0.
// - differential channel results are delivered in two's complement.
// - after a low byte read, results stay frozen until high is read.
// - trigger source field acts only while auto triggering is enabled.
// - auto triggering starts a conversion on each rising selected flag seen while idle.
// - switching from a clear source to a set one counts as edge.
// - switching to free running never makes a trigger by itself.
// - trigger codes map free run, comparator, int0, timer flags.
// - done flag sets on result write; vector or written one clears.
// - changing left adjust changes result presentation at once.
// - first conversion 25 converter cycles, later 13; start reads busy.
module conv_trigger_result
   import conv_pkg::*;
#(
   parameter int RESULT_W = RES_W
)
(
   // clock and reset
   input  wire logic           clk,
   input  wire logic           sys_rst,
   // register port
   input  wire reg_req_t       reg_req,
   output logic [7:0]          reg_rdata,
   // processor interrupt side
   input  wire logic           cpu_global_irq_enable,
   input  wire logic           irq_vector_ack,
   output logic                conv_done_irq_request,
   output logic                event_irq,
   // on-chip trigger event flags, codes 1 to 7
   input  wire logic [7:1]     trig_flags,
   // analog core
   input  wire logic [9:0]     core_result,
   output logic                core_enable,
   output logic                core_clk_tick,
   output logic                core_busy,
   output logic [4:0]          core_channel
);

   // ************************************************************
   // parameter check
   // ************************************************************
   generate
      if (RESULT_W != RES_W) begin : g_bad_width
         $error("result width must be 10 to fit the two byte layout");
      end
   endgenerate

   // ************************************************************
   // register state
   // ************************************************************
   logic              conv_enable;
   logic              auto_trigger_enable;
   logic              conv_done_flag;
   logic              conv_done_irq_enable;
   logic [2:0]        conv_clock_divider_select;
   logic              result_left_align;
   logic [4:0]        input_channel_bits;
   logic [2:0]        auto_trigger_source_select;
   logic [3:0]        special_other_bits;
   logic [EVT_N-1:0]  event_status;
   logic [EVT_N-1:0]  event_mask;
   logic [9:0]        conversion_result_bits;
   logic              result_locked;

   // conversion state
   conv_state_t       state;
   conv_state_t       next_state;
   logic [4:0]        ticks_left;
   logic [4:0]        next_ticks_left;
   logic              first_pending;
   logic [4:0]        conv_channel;
   logic              tick;

   // trigger edge state
   logic              trig_prev_level;
   logic [2:0]        trig_prev_select;

   // ************************************************************
   // register decode
   // ************************************************************
   wire wr_control = reg_req.wr && (reg_req.addr == OFS_CONTROL_STATUS);
   wire wr_input   = reg_req.wr && (reg_req.addr == OFS_INPUT_SELECT);
   wire wr_special = reg_req.wr && (reg_req.addr == OFS_SPECIAL_FUNC);
   wire wr_status  = reg_req.wr && (reg_req.addr == OFS_EVENT_STATUS);
   wire wr_mask    = reg_req.wr && (reg_req.addr == OFS_EVENT_MASK);
   wire rd_low     = reg_req.rd && (reg_req.addr == OFS_RESULT_LOW);
   wire rd_high    = reg_req.rd && (reg_req.addr == OFS_RESULT_HIGH);

   // software start and flag clear carried on the control write
   wire sw_start   = wr_control && reg_req.wdata[CS_START_BIT];
   wire sw_clear   = wr_control && reg_req.wdata[CS_FLAG_BIT];
   wire enable_new = wr_control ? reg_req.wdata[CS_ENABLE_BIT] : conv_enable;

   // ************************************************************
   // converter clock
   // ************************************************************
   conv_clock_prescaler u_prescaler (
      .clk            (clk),
      .sys_rst        (sys_rst),
      .run            (conv_enable),
      .divider_select (conv_clock_divider_select),
      .tick           (tick)
   );

   // ************************************************************
   // trigger selection and edge detection
   // ************************************************************
   wire [7:0] trig_vector = {trig_flags, conv_done_flag};
   wire       trig_level  = trig_vector[auto_trigger_source_select];
   // entering free running is not an edge even with the flag already set
   wire       into_free   = (auto_trigger_source_select == TRIG_FREE_RUN)
                          && (trig_prev_select != TRIG_FREE_RUN);
   // a change of select that lifts the level is an edge as well
   wire       trig_rise   = trig_level && !trig_prev_level && !into_free;
   wire       auto_start  = auto_trigger_enable && conv_enable && trig_rise;

   // ************************************************************
   // conversion sequencer
   // ************************************************************
   wire busy        = (state != CONV_IDLE);
   wire start_req   = (sw_start && enable_new) || auto_start;
   wire start_now   = (state == CONV_IDLE) && start_req && enable_new;
   wire missed_trig = auto_start && busy;
   wire last_tick   = (state == CONV_RUN) && tick && (ticks_left == 5'h01);
   wire finishing   = (state == CONV_END);
   wire write_res   = finishing && !result_locked;
   wire lost_res    = finishing && result_locked;

   // differential pairs come from the core offset binary; flip the sign bit
   wire       diff_sel    = (conv_channel >= DIFF_FIRST_CODE)
                         && (conv_channel <= DIFF_LAST_CODE);
   wire [9:0] coded_res   = diff_sel ? {~core_result[9], core_result[8:0]}
                                     : core_result;

   // next state of the sequencer
   always_comb begin
      next_state      = state;
      next_ticks_left = ticks_left;
      case (state)
         CONV_IDLE: begin
            if (start_now) begin
               next_state      = CONV_RUN;
               next_ticks_left = first_pending ? CONV_FIRST_CYCLES
                                               : CONV_NORMAL_CYCLES;
            end
         end
         CONV_RUN: begin
            if (last_tick) begin
               next_state = CONV_END;
            end else if (tick) begin
               next_ticks_left = 5'(ticks_left - 5'h01);
            end
         end
         CONV_END: begin
            next_state = CONV_IDLE;
         end
         default: begin
            next_state = CONV_IDLE;
         end
      endcase
      // turning the converter off ends any conversion at once
      if (!enable_new) begin
         next_state = CONV_IDLE;
      end
   end

   // sequencer registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state      <= CONV_IDLE;
         ticks_left <= 5'h00;
      end else begin
         state      <= next_state;
         ticks_left <= next_ticks_left;
      end
   end

   // first conversion marker, armed while off, spent on the next start
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         first_pending <= 1'b1;
      end else if (!enable_new) begin
         first_pending <= 1'b1;
      end else if (start_now) begin
         first_pending <= 1'b0;
      end
   end

   // channel taken at start so a mid conversion change waits
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         conv_channel <= 5'h00;
      end else if (start_now) begin
         conv_channel <= input_channel_bits;
      end
   end

   // trigger history for edge detection
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         trig_prev_level  <= 1'b0;
         trig_prev_select <= TRIG_FREE_RUN;
      end else begin
         trig_prev_level  <= trig_level;
         trig_prev_select <= auto_trigger_source_select;
      end
   end

   // ************************************************************
   // result pair and read lock
   // ************************************************************
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         conversion_result_bits <= RESULT_RESET;
      end else if (write_res) begin
         conversion_result_bits <= coded_res;
      end
   end

   // low byte read freezes the pair, high byte read frees it
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         result_locked <= 1'b0;
      end else if (rd_high) begin
         result_locked <= 1'b0;
      end else if (rd_low) begin
         result_locked <= 1'b1;
      end
   end

   // presentation follows the align bit with no delay
   wire [7:0] view_low  = result_left_align
                        ? {conversion_result_bits[1:0], 6'h00}
                        : conversion_result_bits[7:0];
   wire [7:0] view_high = result_left_align
                        ? conversion_result_bits[9:2]
                        : {6'h00, conversion_result_bits[9:8]};

   // ************************************************************
   // control, select and special function registers
   // ************************************************************
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         conv_enable               <= CONTROL_RESET[CS_ENABLE_BIT];
         auto_trigger_enable       <= CONTROL_RESET[CS_AUTO_BIT];
         conv_done_irq_enable      <= CONTROL_RESET[CS_IRQ_EN_BIT];
         conv_clock_divider_select <= CONTROL_RESET[CS_DIV_LSB +: 3];
      end else if (wr_control) begin
         conv_enable               <= reg_req.wdata[CS_ENABLE_BIT];
         auto_trigger_enable       <= reg_req.wdata[CS_AUTO_BIT];
         conv_done_irq_enable      <= reg_req.wdata[CS_IRQ_EN_BIT];
         conv_clock_divider_select <= reg_req.wdata[CS_DIV_LSB +: 3];
      end
   end

   // align bit and channel bits
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         result_left_align  <= INPUT_SEL_RESET[IS_LEFT_BIT];
         input_channel_bits <= INPUT_SEL_RESET[IS_CHAN_LSB +: 5];
      end else if (wr_input) begin
         result_left_align  <= reg_req.wdata[IS_LEFT_BIT];
         input_channel_bits <= reg_req.wdata[IS_CHAN_LSB +: 5];
      end
   end

   // trigger select and the unrelated low bits; reserved bit not stored
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         auto_trigger_source_select <= SPECIAL_RESET[SF_TRIG_LSB +: 3];
         special_other_bits         <= SPECIAL_RESET[SF_OTHER_LSB +: 4];
      end else if (wr_special) begin
         auto_trigger_source_select <= reg_req.wdata[SF_TRIG_LSB +: 3];
         special_other_bits         <= reg_req.wdata[SF_OTHER_LSB +: 4];
      end
   end

   // ************************************************************
   // completion flag
   // ************************************************************
   // a new result in the clearing cycle keeps the flag set
   wire next_done_flag = write_res
                      || (conv_done_flag && !sw_clear && !irq_vector_ack);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         conv_done_flag <= CONTROL_RESET[CS_FLAG_BIT];
      end else begin
         conv_done_flag <= next_done_flag;
      end
   end

   // ************************************************************
   // sticky events and mask
   // ************************************************************
   wire [EVT_N-1:0] event_set;
   assign event_set[EVT_DONE_BIT]   = write_res;
   assign event_set[EVT_LOST_BIT]   = lost_res;
   assign event_set[EVT_MISSED_BIT] = missed_trig;

   // one sticky bit per event, set beats the write of one
   genvar gi;
   generate
      for (gi = 0; gi < EVT_N; gi++) begin : g_event
         always_ff @(posedge clk) begin
            if (sys_rst) begin
               event_status[gi] <= EVENT_RESET[gi];
            end else begin
               event_status[gi] <= event_set[gi]
                  || (event_status[gi] && !(wr_status && reg_req.wdata[gi]));
            end
         end
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         event_mask <= EVENT_RESET;
      end else if (wr_mask) begin
         event_mask <= reg_req.wdata[EVT_N-1:0];
      end
   end

   // ************************************************************
   // read data, one cycle after the strobe
   // ************************************************************
   wire [7:0] control_view = {conv_enable, busy, auto_trigger_enable, conv_done_flag,
                              conv_done_irq_enable, conv_clock_divider_select};
   wire [7:0] select_view  = {2'h0, result_left_align, input_channel_bits};
   wire [7:0] special_view = {auto_trigger_source_select, 1'b0,
                              special_other_bits};
   wire [7:0] status_view  = {5'h00, event_status};
   wire [7:0] mask_view    = {5'h00, event_mask};

   logic [7:0] read_mux;
   always_comb begin
      case (reg_req.addr)
         OFS_CONTROL_STATUS: read_mux = control_view;
         OFS_INPUT_SELECT:   read_mux = select_view;
         OFS_RESULT_LOW:     read_mux = view_low;
         OFS_RESULT_HIGH:    read_mux = view_high;
         OFS_SPECIAL_FUNC:   read_mux = special_view;
         OFS_EVENT_STATUS:   read_mux = status_view;
         OFS_EVENT_MASK:     read_mux = mask_view;
         default:            read_mux = 8'h00;
      endcase
   end

   // data only in the cycle after a read strobe
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         reg_rdata <= 8'h00;
      end else begin
         reg_rdata <= reg_req.rd ? read_mux : 8'h00;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   assign conv_done_irq_request = conv_done_flag && conv_done_irq_enable
                               && cpu_global_irq_enable;
   assign event_irq     = |(event_status & event_mask);
   assign core_enable   = conv_enable;
   assign core_clk_tick = tick;
   assign core_busy     = busy;
   assign core_channel  = conv_channel;

endmodule

// *** pkg/conv_pkg.sv ***
// constants, field layouts and types shared by the converter control logic
package conv_pkg;

   // ************************************************************
   // widths
   // ************************************************************
   localparam int ADDR_W = 3;
   localparam int DATA_W = 8;
   localparam int RES_W  = 10;
   localparam int EVT_N  = 3;

   // ************************************************************
   // register offsets (word index on the plain register port)
   // ************************************************************
   localparam logic [2:0] OFS_CONTROL_STATUS = 3'h0; // converter_control_status
   localparam logic [2:0] OFS_INPUT_SELECT   = 3'h1; // input_select_register
   localparam logic [2:0] OFS_RESULT_LOW     = 3'h2; // result_low_byte
   localparam logic [2:0] OFS_RESULT_HIGH    = 3'h3; // result_high_byte
   localparam logic [2:0] OFS_SPECIAL_FUNC   = 3'h4; // special_function_control
   localparam logic [2:0] OFS_EVENT_STATUS   = 3'h5; // sticky events, write one to clear
   localparam logic [2:0] OFS_EVENT_MASK     = 3'h6; // event interrupt mask

   // ************************************************************
   // field positions
   // ************************************************************
   localparam int CS_ENABLE_BIT   = 7;
   localparam int CS_START_BIT    = 6;
   localparam int CS_AUTO_BIT     = 5;
   localparam int CS_FLAG_BIT     = 4;
   localparam int CS_IRQ_EN_BIT   = 3;
   localparam int CS_DIV_LSB      = 0;
   localparam int IS_LEFT_BIT     = 5;
   localparam int IS_CHAN_LSB     = 0;
   localparam int SF_TRIG_LSB     = 5;
   localparam int SF_RSVD_BIT     = 4;
   localparam int SF_OTHER_LSB    = 0;
   localparam int EVT_DONE_BIT    = 0; // result written to data registers
   localparam int EVT_LOST_BIT    = 1; // result dropped while pair locked
   localparam int EVT_MISSED_BIT  = 2; // trigger edge while converting

   // ************************************************************
   // reset values
   // ************************************************************
   localparam logic [7:0] CONTROL_RESET   = 8'h00;
   localparam logic [7:0] INPUT_SEL_RESET = 8'h00;
   localparam logic [7:0] SPECIAL_RESET   = 8'h00;
   localparam logic [2:0] EVENT_RESET     = 3'h0;
   localparam logic [9:0] RESULT_RESET    = 10'h000;

   // ************************************************************
   // conversion lengths in converter clock cycles
   // ************************************************************
   localparam logic [4:0] CONV_FIRST_CYCLES  = 5'h19; // 25, first after enable
   localparam logic [4:0] CONV_NORMAL_CYCLES = 5'h0D; // 13

   // differential channel codes on the input channel bits
   localparam logic [4:0] DIFF_FIRST_CODE = 5'h08;
   localparam logic [4:0] DIFF_LAST_CODE  = 5'h1D;

   // ************************************************************
   // types
   // ************************************************************
   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } reg_req_t;

   typedef enum logic [1:0] {
      CONV_IDLE = 2'b00,
      CONV_RUN  = 2'b01,
      CONV_END  = 2'b11
   } conv_state_t;

   typedef enum logic [2:0] {
      TRIG_FREE_RUN     = 3'h0,
      TRIG_COMPARATOR   = 3'h1,
      TRIG_EXT_IRQ0     = 3'h2,
      TRIG_T0_COMPARE   = 3'h3,
      TRIG_T0_OVERFLOW  = 3'h4,
      TRIG_T1_COMPARE_B = 3'h5,
      TRIG_T1_OVERFLOW  = 3'h6,
      TRIG_T1_CAPTURE   = 3'h7
   } trig_src_t;

endpackage

// *** rtl/conv_clock_prescaler.sv ***
// divider that makes the converter clock tick from the system clock
`timescale 1ns/1ps
module conv_clock_prescaler
   import conv_pkg::*;
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       sys_rst,
   // control
   input  wire logic       run,
   input  wire logic [2:0] divider_select,
   // converter clock tick, one system cycle wide
   output logic            tick
);

   // ************************************************************
   // division factor
   // ************************************************************
   logic [6:0] count;
   logic [6:0] next_count;
   logic [6:0] terminal;
   logic       wrap;

   // codes 0 and 1 both divide by 2, then powers of two up to 128
   assign terminal   = (divider_select <= 3'h1) ? 7'h01
                     : 7'((8'h01 << divider_select) - 8'h01);
   assign wrap       = (count >= terminal);
   assign next_count = (!run || wrap) ? 7'h00 : 7'(count + 7'h01);

   // free counter, held at zero while the converter is off
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         count <= 7'h00;
         tick  <= 1'b0;
      end else begin
         count <= next_count;
         tick  <= run && wrap;
      end
   end

endmodule

// *** sim/conv_core_model.sv ***
// behavioural analog core that answers with a channel-derived sample
`timescale 1ns/1ps
module conv_core_model (
   // from the converter control
   input  wire logic       core_enable,
   input  wire logic [4:0] core_channel,
   // raw sample, offset binary on differential channels
   output logic [9:0]      core_result
);
   // a powered-down core shows 10'h2AA, the same pattern that channel 5'h15 would give
   assign core_result = core_enable ? {core_channel, ~core_channel} : 10'h2AA;
endmodule

// *** sim/conv_trigger_result_chk.sv ***
// port-level assertions for the converter trigger and result logic
`timescale 1ns/1ps
module conv_trigger_result_chk
   import conv_pkg::*;
(
   // clock and reset
   input wire logic       clk,
   input wire logic       sys_rst,
   // register port and interrupts
   input wire reg_req_t   reg_req,
   input wire logic [7:0] reg_rdata,
   input wire logic       cpu_global_irq_enable,
   input wire logic       irq_vector_ack,
   input wire logic       conv_done_irq_request,
   input wire logic       event_irq,
   // trigger flags and analog core
   input wire logic [7:1] trig_flags,
   input wire logic [9:0] core_result,
   input wire logic       core_enable,
   input wire logic       core_clk_tick,
   input wire logic       core_busy,
   input wire logic [4:0] core_channel
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // interrupt request and flag clearing
   irq_gate_a: assert property (conv_done_irq_request |-> cpu_global_irq_enable)
      else $error("done request without global enable");
   ack_clear_a: assert property (irq_vector_ack && !core_busy && !$past(core_busy)
      |=> !conv_done_irq_request) else $error("vector ack left request up");
   // converter clock ticks
   tick_gap_a: assert property (core_clk_tick |=> !core_clk_tick)
      else $error("ticks closer than two cycles");
   tick_off_a: assert property (!core_enable [*2] |-> !core_clk_tick)
      else $error("tick while disabled");
   // conversion in progress
   busy_off_a: assert property (!core_enable |-> !core_busy)
      else $error("busy while disabled");
   busy_len_a: assert property ($rose(core_busy) |-> (core_busy || !core_enable) [*8])
      else $error("conversion too short");
   // read data
   rsvd_zero_a: assert property ($past(reg_req.rd) && $past(reg_req.addr) == OFS_SPECIAL_FUNC
      |-> !reg_rdata[SF_RSVD_BIT]) else $error("reserved bit read as one");
   unmap_a: assert property (reg_req.rd && reg_req.addr == 3'h7 |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   rdata_idle_a: assert property (!$past(reg_req.rd) |-> reg_rdata == 8'h00)
      else $error("read data outside read slot");
   // main scenarios reached
   cover property ($fell(core_busy));
   cover property (conv_done_irq_request);
   cover property (event_irq);
   cover property ($rose(core_busy) && !$past(reg_req.wr));
endmodule
bind conv_trigger_result conv_trigger_result_chk chk_i (.clk(clk), .sys_rst(sys_rst),
   .reg_req(reg_req), .reg_rdata(reg_rdata), .cpu_global_irq_enable(cpu_global_irq_enable),
   .irq_vector_ack(irq_vector_ack), .conv_done_irq_request(conv_done_irq_request),
   .event_irq(event_irq), .trig_flags(trig_flags), .core_result(core_result),
   .core_enable(core_enable), .core_clk_tick(core_clk_tick), .core_busy(core_busy),
   .core_channel(core_channel));

// *** sim/conv_trigger_result_tb.sv ***
// self-checking bench for the converter trigger and result logic
`timescale 1ns/1ps
module conv_trigger_result_tb;
   import conv_pkg::*;
   logic       clk = 0, sys_rst = 1, gie = 0, ack = 0;
   reg_req_t   rq = '0;
   logic [7:1] flags = '0;
   logic [7:0] rdat;
   logic [9:0] res;
   logic       irq, eirq, en, tick, busy;
   logic [4:0] ch;
   int         error_cnt = 0, num_checks = 0;
   // 125 MHz system clock
   always #4 clk = ~clk;
   conv_trigger_result dut (.clk(clk), .sys_rst(sys_rst), .reg_req(rq), .reg_rdata(rdat),
      .cpu_global_irq_enable(gie), .irq_vector_ack(ack), .conv_done_irq_request(irq),
      .event_irq(eirq), .trig_flags(flags), .core_result(res), .core_enable(en),
      .core_clk_tick(tick), .core_busy(busy), .core_channel(ch));
   conv_core_model core (.core_enable(en), .core_channel(ch), .core_result(res));
   // compare, count and report
   task automatic chk(input logic [9:0] got, input logic [9:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // one-cycle register strobes
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk) rq <= '{a, d, 1'b1, 1'b0};
      @(posedge clk) rq.wr <= 1'b0;
   endtask
   task automatic rdchk(input logic [2:0] a, input logic [7:0] exp);
      @(posedge clk) rq <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk) rq.rd <= 1'b0;
      #1 chk(rdat, exp);
   endtask
   task automatic wait_for(input logic lvl, input int lim);
      int n = 0;
      while (busy !== lvl && n < lim) begin
         @(posedge clk) #1 n++;
      end
      chk(busy, lvl);
   endtask
   task automatic pulse_ack;
      @(posedge clk) ack <= 1'b1;
      @(posedge clk) ack <= 1'b0;
      #1 chk(irq, 1'b0);
   endtask
   // raw core pattern, sign bit flipped on differential channels
   function automatic logic [9:0] exp_res(input logic [4:0] c);
      exp_res = {c, ~c};
      if (c >= DIFF_FIRST_CODE && c <= DIFF_LAST_CODE) exp_res[9] = ~exp_res[9];
   endfunction
   task automatic convert(input logic [4:0] c);
      wr(OFS_INPUT_SELECT, {3'h0, c});
      wr(OFS_CONTROL_STATUS, 8'hC8);
      wait_for(1'b1, 8);
      wait_for(1'b0, 4000);
   endtask
   task automatic t_result;
      logic [9:0] r;
      r = exp_res(5'h1D);
      for (int a = 0; a < 8; a++) rdchk(a[2:0], 8'h00);
      gie <= 1'b1;
      wr(OFS_EVENT_MASK, 8'h01);
      convert(5'h1D);
      rdchk(OFS_RESULT_LOW, r[7:0]);
      rdchk(OFS_RESULT_HIGH, {6'h00, r[9:8]});
      chk(irq, 1'b1);
      chk(eirq, 1'b1);
      wr(OFS_INPUT_SELECT, 8'h3D);
      rdchk(OFS_RESULT_LOW, {r[1:0], 6'h00});
      rdchk(OFS_RESULT_HIGH, r[9:2]);
      gie <= 1'b0;
      @(posedge clk) #1 chk(irq, 1'b0);
      gie <= 1'b1;
      pulse_ack();
      wr(OFS_EVENT_STATUS, 8'h01);
      rdchk(OFS_EVENT_STATUS, 8'h00);
      chk(eirq, 1'b0);
      $display("result test finished");
   endtask
   task automatic t_lock;
      logic [9:0] r;
      r = exp_res(5'h07);
      convert(5'h07);
      pulse_ack();
      rdchk(OFS_RESULT_LOW, r[7:0]);
      convert(5'h1D);
      chk(irq, 1'b0);
      rdchk(OFS_RESULT_HIGH, {6'h00, r[9:8]});
      rdchk(OFS_EVENT_STATUS, 8'h03);
      $display("lock test finished");
   endtask
   task automatic t_prescale;
      int n;
      for (int k = 0; k < 8; k++) begin
         wr(OFS_CONTROL_STATUS, 8'hC0 | k[7:0]);
         n = 0;
         do @(posedge clk) #1 n++; while (tick !== 1'b1 && n < 300);
         n = 0;
         do @(posedge clk) #1 n++; while (tick !== 1'b1 && n < 300);
         chk(n[9:0], (k < 2) ? 10'h002 : 10'h001 << k);
         wait_for(1'b0, 4000);
      end
      $display("prescaler test finished");
   endtask
   task automatic t_trigger;
      wr(OFS_CONTROL_STATUS, 8'h80);
      wr(OFS_SPECIAL_FUNC, 8'h6F);
      rdchk(OFS_SPECIAL_FUNC, 8'h6F);
      @(posedge clk) flags[3] <= 1'b1;
      repeat (4) @(posedge clk);
      #1 chk(busy, 1'b0);
      wr(OFS_CONTROL_STATUS, 8'hA0);
      for (int s = 1; s < 8; s++) begin
         wr(OFS_SPECIAL_FUNC, {s[2:0], 5'h00});
         @(posedge clk) flags <= '0;
         @(posedge clk) flags[s] <= 1'b1;
         wait_for(1'b1, 4);
         wait_for(1'b0, 4000);
      end
      @(posedge clk) flags[5] <= 1'b1;
      wr(OFS_SPECIAL_FUNC, 8'h80);
      wr(OFS_SPECIAL_FUNC, 8'hA0);
      wait_for(1'b1, 4);
      // a fresh edge while converting is dropped and logged as missed
      @(posedge clk) flags[5] <= 1'b0;
      @(posedge clk) flags[5] <= 1'b1;
      wait_for(1'b0, 4000);
      rdchk(OFS_EVENT_STATUS, 8'h07);
      // leave from a clear source so only the suppression keeps it quiet
      wr(OFS_SPECIAL_FUNC, 8'h80);
      wr(OFS_SPECIAL_FUNC, 8'h00);
      repeat (4) @(posedge clk);
      #1 chk(busy, 1'b0);
      $display("trigger test finished");
   endtask
   // watchdog against a hung wait
   initial begin
      #400_000;
      error_cnt++;
      close_out();
   end
   initial begin
      repeat (16) @(posedge clk);
      sys_rst <= 1'b0;
      t_result();
      t_lock();
      t_prescale();
      t_trigger();
      close_out();
   end
endmodule
